// ### hw/mfpd_pkg.sv
package mfpd_pkg;
  // Sample and coefficient widths
  localparam int IN_W = 8;
  localparam int COEF_W = 6;
  // Tap counts: baseline, least useful, largest supported
  localparam int TAPS = 6;
  localparam int MIN_TAPS = 5;
  localparam int MAX_TAPS = 8;
  // Coefficient index width
  localparam int IDX_W = $clog2(MAX_TAPS);
  // Accumulator width: full sum of MAX_TAPS products
  localparam int ACC_W = IN_W + COEF_W + $clog2(MAX_TAPS);
  // Input buffer depth
  localparam int FIFO_DEPTH = 8;
  // Samples per beam crossing
  localparam int SAMPLES_PER_BC = 2;
  // Sample rate and system clock rate, in kHz
  localparam int SAMPLE_RATE_KHZ = 15140;
  localparam int CLK_RATE_KHZ = 25000;
  // Least clock cycles between two samples, rounded down, at least one
  localparam int CLK_PER_SAMPLE = (CLK_RATE_KHZ / SAMPLE_RATE_KHZ < 1) ? 1 :
                                  CLK_RATE_KHZ / SAMPLE_RATE_KHZ;
  // Expected pulse shape, first sample first; reset coefficients derive from it
  localparam logic [COEF_W-1:0] PULSE_SHAPE [0:MAX_TAPS-1] = '{
    6'h06, 6'h1c, 6'h3f, 6'h33, 6'h1e, 6'h0c, 6'h04, 6'h01
  };

  // One ADC sample with its beam-crossing half
  typedef struct packed {
    logic [IN_W-1:0] adc;
    logic first_half;
  } mfpd_sample_t;

  // One result per beam crossing
  typedef struct packed {
    logic [ACC_W-1:0] energy;
    logic peak;
  } mfpd_bc_out_t;
endpackage

// ### hw/mfpd_fifo.sv
module mfpd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Drain side
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage, pointers and fill level
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // Honest full and empty flags
  assign wr_ready = (count_q != (PW+1)'(DEPTH));
  assign rd_valid = (count_q != '0);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem[rd_ptr_q];

  // Pointer wrap at depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == (PW)'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Write storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= bump(wr_ptr_q);
      if (pop)
        rd_ptr_q <= bump(rd_ptr_q);
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule

// ### hw/mfpd_coef_store.sv
module mfpd_coef_store #(
  parameter int TAPS = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load port
  input wire logic wr_en,
  input wire logic [mfpd_pkg::IDX_W-1:0] wr_idx,
  input wire logic [mfpd_pkg::COEF_W-1:0] wr_data,
  // Coefficients to the datapath
  output logic [mfpd_pkg::COEF_W-1:0] coef [0:TAPS-1]
);
  // Loadable taps; reset fills the time-reversed pulse shape
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < TAPS; k++)
        coef[k] <= mfpd_pkg::PULSE_SHAPE[TAPS-1-k];
    end
    else if (wr_en && (int'(wr_idx) < TAPS))
    begin
      coef[wr_idx] <= wr_data;
    end
  end

  // Reset taps are the reversed pulse
  coef_reset_a: assert property (@(posedge clk) $fell(rst) |->
    coef[0] == mfpd_pkg::PULSE_SHAPE[TAPS-1] && coef[TAPS-1] == mfpd_pkg::PULSE_SHAPE[0])
    else $error("reset taps not reversed pulse");

  // A load lands at its index
  coef_load_a: assert property (@(posedge clk) disable iff (rst)
    wr_en && (int'(wr_idx) < TAPS) |=> coef[$past(wr_idx)] == $past(wr_data))
    else $error("tap load lost");
endmodule

// ### hw/mfpd_top.sv
// Functional notes
// - Taps are the expected pulse reversed
// - Window is whole samples, sets taps, latency
// - Filter peak one window after input
// - Same total latency for every channel
// - Peak: k below k-1, k-1 above k-2
// - Peak stage adds exactly one sample
// - Zero unless peak, else filter value
// - Samples processed at twice crossing rate
// - 8-bit samples, six 6-bit taps, fixed point
// - At least five taps; eight costs one crossing
// - One output per beam crossing
module mfpd_top #(
  parameter int TAPS = mfpd_pkg::TAPS,
  parameter int FIFO_DEPTH = mfpd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // ADC sample stream
  input wire mfpd_pkg::mfpd_sample_t in_sample,
  input wire logic in_valid,
  output logic in_ready,
  // Tap coefficient load
  input wire logic coef_wr_en,
  input wire logic [mfpd_pkg::IDX_W-1:0] coef_wr_idx,
  input wire logic [mfpd_pkg::COEF_W-1:0] coef_wr_data,
  // Beam-crossing result stream
  output mfpd_pkg::mfpd_bc_out_t bc_out,
  output logic bc_valid,
  input wire logic bc_ready
);
  // Local copies of widths for casts
  localparam int AW = mfpd_pkg::ACC_W;
  localparam int IW = mfpd_pkg::IN_W;
  localparam int CW = mfpd_pkg::COEF_W;
  localparam int SW = $bits(mfpd_pkg::mfpd_sample_t);
  // Padding that equalises latency to the largest window
  localparam int PAD = mfpd_pkg::MAX_TAPS - TAPS;
  // Largest possible filter value
  localparam logic [AW-1:0] ACC_MAX = AW'(TAPS * (2**IW - 1) * (2**CW - 1));

  // Buffered sample stream
  mfpd_pkg::mfpd_sample_t fifo_sample;
  logic [SW-1:0] fifo_bits;
  logic fifo_valid;
  // One step of the whole pipeline
  logic adv;
  // Taps from the loadable store
  logic [CW-1:0] coef [0:TAPS-1];
  // Sample window, newest first
  logic [IW-1:0] win_q [0:TAPS-1];
  logic [IW-1:0] win_d [0:TAPS-1];
  // Filter sum for the incoming step
  logic [AW-1:0] acc_d;
  // Filter output and its half flag
  logic [AW-1:0] filt_q;
  logic filt_ph_q;
  // Padded filter output
  logic [AW-1:0] tail;
  logic tail_ph;
  // Two previous filter values for the peak test
  logic [AW-1:0] f1_q;
  logic [AW-1:0] f2_q;
  logic f1_ph_q;
  // Peak test result
  logic peak_now;
  logic [AW-1:0] peak_val;
  // First-half result held for pairing
  logic [AW-1:0] hold_q;
  // Emit one result per crossing
  logic emit;

  // Input buffer; its ready is the block's ready
  mfpd_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .wr_data(in_sample),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .rd_data(fifo_bits),
    .rd_valid(fifo_valid),
    .rd_ready(adv)
  );
  assign fifo_sample = mfpd_pkg::mfpd_sample_t'(fifo_bits);

  // Tap storage
  mfpd_coef_store #(
    .TAPS(TAPS)
  ) u_coef (
    .clk(clk),
    .rst(rst),
    .wr_en(coef_wr_en),
    .wr_idx(coef_wr_idx),
    .wr_data(coef_wr_data),
    .coef(coef)
  );

  // Step when a sample waits and the result slot can take a value
  assign adv = fifo_valid && (!bc_valid || bc_ready);

  // Next window: new sample in front, oldest falls out
  always_comb
  begin
    win_d[0] = fifo_sample.adc;
    for (int k = 1; k < TAPS; k++)
    begin
      win_d[k] = win_q[k-1];
    end
  end

  // Unsigned fixed-point multiply-accumulate over the window
  always_comb
  begin
    acc_d = '0;
    for (int k = 0; k < TAPS; k++)
    begin
      acc_d = acc_d + AW'(win_d[k]) * AW'(coef[k]);
    end
  end

  // Window shift register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < TAPS; k++)
        win_q[k] <= '0;
    end
    else if (adv)
    begin
      win_q <= win_d;
    end
  end

  // Filter output register, one step per sample
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      filt_q <= '0;
      filt_ph_q <= 1'b0;
    end
    else if (adv)
    begin
      filt_q <= acc_d;
      filt_ph_q <= fifo_sample.first_half;
    end
  end

  // Latency padding up to the largest window
  generate
    if (PAD == 0)
    begin : g_nopad
      // Largest window: no padding
      assign tail = filt_q;
      assign tail_ph = filt_ph_q;
    end
    else
    begin : g_pad
      // Delay line of PAD samples
      logic [AW-1:0] pad_q [0:PAD-1];
      logic pad_ph_q [0:PAD-1];
      // Phase flags reset to the alternating pattern run backwards, so that
      // tap counts with even padding (six, eight) emit on the same steps after reset
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          for (int i = 0; i < PAD; i++)
          begin
            pad_q[i] <= '0;
            pad_ph_q[i] <= ((i % 2) == 0);
          end
        end
        else if (adv)
        begin
          pad_q[0] <= filt_q;
          pad_ph_q[0] <= filt_ph_q;
          for (int i = 1; i < PAD; i++)
          begin
            pad_q[i] <= pad_q[i-1];
            pad_ph_q[i] <= pad_ph_q[i-1];
          end
        end
      end
      assign tail = pad_q[PAD-1];
      assign tail_ph = pad_ph_q[PAD-1];
    end
  endgenerate

  // Previous two filter values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      f1_q <= '0;
      f2_q <= '0;
      // Continues the backward phase pattern behind the padding
      f1_ph_q <= ((PAD % 2) == 0);
    end
    else if (adv)
    begin
      f1_q <= tail;
      f2_q <= f1_q;
      f1_ph_q <= tail_ph;
    end
  end

  // Three-point strict peak test on the middle value
  assign peak_now = (tail < f1_q) && (f1_q > f2_q);
  // Zero when no peak, else the filter value
  assign peak_val = peak_now ? f1_q : '0;

  // Result goes out once, on the second half of a crossing
  assign emit = adv && !f1_ph_q;

  // First-half result waits for its partner
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_q <= '0;
    end
    else if (adv && f1_ph_q)
    begin
      hold_q <= peak_val;
    end
    else if (emit)
    begin
      hold_q <= '0;
    end
  end

  // Result register; two strict peaks cannot share a crossing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bc_out <= '0;
    end
    else if (emit)
    begin
      bc_out.energy <= hold_q | peak_val;
      bc_out.peak <= ((hold_q | peak_val) != '0);
    end
  end

  // Result valid flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bc_valid <= 1'b0;
    end
    else if (emit)
    begin
      bc_valid <= 1'b1;
    end
    else if (bc_ready)
    begin
      bc_valid <= 1'b0;
    end
  end

  // Steps of the peak decision
  sequence s_peak_step;
    adv && peak_now && f1_ph_q;
  endsequence
  sequence s_flat_step;
    adv && !peak_now && f1_ph_q;
  endsequence

  // Tap count never below the useful minimum
  taps_min_a: assert property (@(posedge clk) disable iff (rst)
    TAPS >= mfpd_pkg::MIN_TAPS && TAPS <= mfpd_pkg::MAX_TAPS)
    else $error("tap count out of range");

  // Peak holds the middle filter value
  peak_value_a: assert property (@(posedge clk) disable iff (rst)
    s_peak_step |=> hold_q == $past(f1_q) && hold_q > $past(f2_q))
    else $error("peak value wrong");

  // No peak gives zero
  zero_out_a: assert property (@(posedge clk) disable iff (rst)
    s_flat_step |=> hold_q == '0)
    else $error("non-peak not zero");

  // With no padding, the filter value reaches the peak stage one step later
  pad_delay_a: assert property (@(posedge clk) disable iff (rst)
    adv && (PAD == 0) |=> f1_q == $past(filt_q))
    else $error("unpadded path delay wrong");

  // Results appear only on a second-half step
  one_per_bc_a: assert property (@(posedge clk) disable iff (rst)
    $rose(bc_valid) |-> $past(adv) && !$past(f1_ph_q))
    else $error("result outside crossing boundary");

  // Stalled result stays put
  out_hold_a: assert property (@(posedge clk) disable iff (rst)
    bc_valid && !bc_ready |=> bc_valid && $stable(bc_out))
    else $error("result dropped under stall");

  // No sample, no movement
  stall_hold_a: assert property (@(posedge clk) disable iff (rst)
    !adv |=> $stable(filt_q) && $stable(f1_q) && $stable(f2_q))
    else $error("pipeline moved without sample");

  // Sum stays within its range
  sum_fits_a: assert property (@(posedge clk) disable iff (rst)
    adv |=> filt_q <= ACC_MAX)
    else $error("filter sum out of range");

  // Peak flag matches nonzero energy
  peak_flag_a: assert property (@(posedge clk) disable iff (rst)
    bc_valid |-> bc_out.peak == (bc_out.energy != '0))
    else $error("peak flag disagrees");
endmodule

// ### verification/mfpd_adc_model.sv
module mfpd_adc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic en,
  // Sample stream
  input wire logic in_ready,
  output mfpd_pkg::mfpd_sample_t in_sample,
  output logic in_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulse position, height, flat-top kind, crossing half
  int pos;
  int amp;
  logic flat;
  logic half;
  // Converted level at the current pulse position
  function automatic logic [7:0] level();
    int v;
    if (pos == 0)
    begin
      amp = $urandom_range(255);
      flat = ($urandom_range(3) == 0);
    end
    v = (pos >= 12) ? 0 : flat ? amp :
        (pos < 8) ? (amp * mfpd_pkg::PULSE_SHAPE[pos]) >> 6 : 0;
    pos = (pos + 1) % 24;
    return v[7:0];
  endfunction
  // Offer a sample, hold it until taken
  always @(posedge clk)
  begin
    if (rst)
    begin
      in_valid <= 1'b0;
      in_sample <= '0;
      half = 1'b1;
      pos = 0;
    end
    else if (!in_valid || in_ready)
    begin
      // Halves alternate per taken sample
      if (in_valid)
        half = !half;
      // About 60 percent of cycles, near the nominal rate
      if (en && $urandom_range(9) < 6)
      begin
        in_valid <= 1'b1;
        in_sample <= '{adc: level(), first_half: half};
      end
      else
      begin
        in_valid <= 1'b0;
        // Released lines show no stale value
        in_sample <= ~in_sample;
      end
    end
  end
endmodule

// ### verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset, bench controls
  logic clk;
  logic rst;
  logic en;
  logic bc_ready;
  // Tap load port, shared by both channels
  logic coef_wr_en;
  logic [mfpd_pkg::IDX_W-1:0] coef_wr_idx;
  logic [mfpd_pkg::COEF_W-1:0] coef_wr_data;
  // Sample stream
  mfpd_pkg::mfpd_sample_t in_sample;
  logic in_valid;
  // Six-tap and eight-tap channel outputs
  logic rdy6, rdy8, val6, val8;
  mfpd_pkg::mfpd_bc_out_t out6, out8;
  // Counters and model state
  int n_fail, cmp_count, cyc, v;
  logic same_taps;
  int coef [0:5];
  int xs[$];
  int fs[$];
  int ev[$];
  logic [mfpd_pkg::ACC_W-1:0] exp_q[$], obs[$];

  // Sample source
  mfpd_adc_model i_adc (.clk(clk), .rst(rst), .en(en), .in_ready(rdy6),
    .in_sample(in_sample), .in_valid(in_valid));
  // Channel under test, baseline taps
  mfpd_top #(.TAPS(6)) i_dut (.clk(clk), .rst(rst), .in_sample(in_sample),
    .in_valid(in_valid), .in_ready(rdy6), .coef_wr_en(coef_wr_en),
    .coef_wr_idx(coef_wr_idx), .coef_wr_data(coef_wr_data), .bc_out(out6),
    .bc_valid(val6), .bc_ready(bc_ready));
  // Eight-tap channel; its taps land two places up, so it equals the padded six-tap
  mfpd_top #(.TAPS(8)) i_dut8 (.clk(clk), .rst(rst), .in_sample(in_sample),
    .in_valid(in_valid), .in_ready(rdy8), .coef_wr_en(coef_wr_en),
    .coef_wr_idx(coef_wr_idx + 3'h2), .coef_wr_data(coef_wr_data), .bc_out(out8),
    .bc_valid(val8), .bc_ready(bc_ready));

  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", name, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reference filter, peak test and crossing pairing
  task automatic model(int x);
    int s, n, p;
    xs.push_back(x);
    n = xs.size() - 1;
    s = 0;
    for (int k = 0; k < 6; k++)
      if (n >= k)
        s += coef[k] * xs[n - k];
    fs.push_back(s);
    p = (n >= 2) ? fs[n - 2] : 0;
    if (n >= 1)
      ev.push_back((fs[n] < fs[n - 1] && fs[n - 1] > p) ? fs[n - 1] : 0);
    if (ev.size() % 2 == 0 && ev.size() > 0)
      exp_q.push_back(ev[ev.size() - 2] | ev[ev.size() - 1]);
  endtask

  // Random sink readiness
  task automatic run(int n);
    repeat (n)
    begin
      bc_ready <= ($urandom_range(3) != 0);
      @(posedge clk);
    end
  endtask

  // Per-edge monitor and timeout
  always @(posedge clk)
  begin
    cyc++;
    if (!rst)
    begin
      if (in_valid && rdy6)
        model(in_sample.adc);
      if (val6 && bc_ready)
      begin
        obs.push_back(out6.energy);
        chk("peak flag", out6.energy != 0, out6.peak);
      end
      chk("ready8", rdy6, rdy8);
      chk("valid8", val6, val8);
      if (same_taps && val6)
        chk("out8", out6, out8);
    end
    if (cyc > 4000)
    begin
      n_fail++;
      final_report();
    end
  end

  // Main sequence
  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    same_taps = 1'b0;
    void'($urandom(62330));
    rst = 1'b1;
    en = 1'b0;
    bc_ready = 1'b1;
    coef_wr_en = 1'b0;
    coef_wr_idx = '0;
    coef_wr_data = '0;
    // Reset taps are the reversed pulse
    for (int k = 0; k < 6; k++)
      coef[k] = mfpd_pkg::PULSE_SHAPE[5 - k];
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    run(800);
    // Sink stalls until the buffer refuses
    bc_ready <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk("in_ready full", 0, rdy6);
    @(posedge clk);
    bc_ready <= 1'b1;
    en <= 1'b0;
    repeat (40) @(posedge clk);
    // Back-to-back tap loads, upper indices ignored by six taps
    for (int k = 0; k < 8; k++)
    begin
      v = (k < 6) ? $urandom_range(63) : 0;
      coef_wr_en <= 1'b1;
      coef_wr_idx <= 3'(k);
      coef_wr_data <= 6'(v);
      if (k < 6)
        coef[k] = v;
      @(posedge clk);
    end
    coef_wr_en <= 1'b0;
    en <= 1'b1;
    run(100);
    same_taps <= 1'b1;
    run(800);
    en <= 1'b0;
    bc_ready <= 1'b1;
    repeat (60) @(posedge clk);
    // Align on first nonzero result, then compare in order
    while (obs.size() > 0 && obs[0] === '0)
      void'(obs.pop_front());
    while (exp_q.size() > 0 && exp_q[0] == 0)
      void'(exp_q.pop_front());
    chk("result count", 1, obs.size() + 8 >= exp_q.size());
    for (int i = 0; i < obs.size(); i++)
      chk("energy", (i < exp_q.size()) ? exp_q[i] : 0, obs[i]);
    final_report();
  end
endmodule
